// ==== mais_pkg.sv ====
// Purpose: constants and types shared by the multi-address two-wire target
// Assumes: 200 MHz system clock, byte-addressed Avalon-MM register window
// Notes: target addresses are 7-bit values without the direction bit

package mais_pkg;

    // ----------------------------------------------------------------
    // target addresses and memory areas
    // ----------------------------------------------------------------
    localparam logic [6:0] AREA_ONE_ADDRESS = 7'h10;
    localparam logic [6:0] AREA_TWO_ADDRESS = 7'h24;
    localparam logic [6:0] AREA_THREE_ADDRESS = 7'h5a;
    localparam logic [6:0] AREA_FOUR_ADDRESS = 7'h6b;
    localparam int AREA_COUNT = 4;
    localparam int AREA_DEPTH = 256;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ----------------------------------------------------------------
    // transfer state codes and link states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        XFER_IDLE = 2'h0,
        XFER_REG_ADDR = 2'h1,
        XFER_SEND = 2'h2,
        XFER_RECV = 2'h3
    } mais_xfer_e;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_ADDR_ACK = 8'h04,
        ST_RX = 8'h08,
        ST_RX_ACK = 8'h10,
        ST_TX = 8'h20,
        ST_TX_ACK = 8'h40,
        ST_IGNORE = 8'h80
    } mais_state_e;

    // ----------------------------------------------------------------
    // register map (byte offsets) and reset values
    // ----------------------------------------------------------------
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STATE = 5'h04;
    localparam logic [4:0] REG_LAST = 5'h08;
    localparam logic [4:0] REG_TARGET = 5'h0c;
    localparam logic [4:0] REG_IRQ_STATUS = 5'h10;
    localparam logic [4:0] REG_IRQ_CLEAR = 5'h14;
    localparam logic [4:0] REG_IRQ_ENABLE = 5'h18;
    localparam logic CTRL_RESET = 1'b1;
    localparam logic [7:0] TARGET_RESET = 8'h00;
    localparam int IRQ_MATCH_BIT = 0;
    localparam int IRQ_REJECT_BIT = 1;
    localparam int IRQ_DONE_BIT = 2;
    localparam int IRQ_WIDTH = 3;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // ----------------------------------------------------------------
    // lamp display
    // ----------------------------------------------------------------
    localparam logic LAMP_ON_LEVEL = 1'b0;
    localparam logic LAMP_OFF_LEVEL = 1'b1;
    localparam int DISPLAY_TIME_MS = 5;
    localparam int CLK_FREQ_KHZ = 200000;
    localparam int DISPLAY_TICK_CYCLES = DISPLAY_TIME_MS * CLK_FREQ_KHZ;

endpackage

// ==== mais_top.sv ====
// Purpose: two-wire target answering four addresses, each with a 256-byte
//          area, plus registers over Avalon-MM and a multiplexed lamp display
// Assumes: controller obeys the two-wire protocol; no clock stretching
// Notes: memory contents are not reset
`timescale 1ns/1ps

module mais_top
    import mais_pkg::*;
#(
    parameter int TICK_CYCLES = DISPLAY_TICK_CYCLES
)
(
    input logic CLK_SYS, // system clock
    input logic RESET, // synchronous reset, high
    input logic [4:0] AVS_ADDRESS, // register byte address
    input logic AVS_READ, // read request
    input logic AVS_WRITE, // write request
    input logic [31:0] AVS_WRITEDATA, // write data
    input logic [3:0] AVS_BYTEENABLE, // byte lanes
    output logic [31:0] AVS_READDATA, // read data
    output logic AVS_WAITREQUEST, // stall
    output logic IRQ, // level interrupt
    input logic SCL_IN, // bus clock level
    input logic SDA_IN, // bus data level
    output logic SDA_OUT, // data drive value
    output logic SDA_OE, // data drive enable
    output logic [3:0] LAMP_DATA_N, // lamp data, low lights
    output logic LAMP_SEL_LOW_N, // low nibble select
    output logic LAMP_SEL_HIGH_N // high nibble select
);

    // ----------------------------------------------------------------
    // pin synchronisers and edge detect
    // ----------------------------------------------------------------
    logic scl_s1_q, scl_s2_q, scl_d_q;
    logic sda_s1_q, sda_s2_q, sda_d_q;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_d_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_d_q <= 1'b1;
        end
        else
        begin
            scl_s1_q <= SCL_IN;
            scl_s2_q <= scl_s1_q;
            scl_d_q <= scl_s2_q;
            sda_s1_q <= SDA_IN;
            sda_s2_q <= sda_s1_q;
            sda_d_q <= sda_s2_q;
        end
    end

    assign scl_rise = scl_s2_q & ~scl_d_q;
    assign scl_fall = ~scl_s2_q & scl_d_q;
    assign start_det = scl_s2_q & scl_d_q & ~sda_s2_q & sda_d_q;
    assign stop_det = scl_s2_q & scl_d_q & sda_s2_q & ~sda_d_q;

    // ----------------------------------------------------------------
    // address decode and shared strobes
    // ----------------------------------------------------------------
    mais_state_e st_q;
    mais_xfer_e xfer_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q, tx_sh_q, target_q;
    logic [1:0] sel_q;
    logic rw_q, nack_q, sda_oe_q, enable_q;
    logic [AREA_COUNT-1:0][7:0] ptr_q;
    logic [7:0] mem_q [AREA_COUNT*AREA_DEPTH];
    logic byte_done, addr_hit, rx_done, ptr_load, mem_we, tx_load;
    logic [1:0] hit_area;
    logic [7:0] tx_byte;

    always_comb
    begin
        addr_hit = enable_q;
        hit_area = 2'h0;
        unique case (shift_q[7:1])
            AREA_ONE_ADDRESS: hit_area = 2'h0;
            AREA_TWO_ADDRESS: hit_area = 2'h1;
            AREA_THREE_ADDRESS: hit_area = 2'h2;
            AREA_FOUR_ADDRESS: hit_area = 2'h3;
            default: addr_hit = 1'b0;
        endcase
    end

    assign byte_done = scl_fall && (bit_cnt_q == BITS_PER_BYTE);
    assign rx_done = byte_done && (st_q == ST_RX);
    assign ptr_load = rx_done && (xfer_q == XFER_REG_ADDR);
    assign mem_we = rx_done && (xfer_q == XFER_RECV);
    assign tx_load = scl_fall && (((st_q == ST_ADDR_ACK) && rw_q)
        || ((st_q == ST_TX_ACK) && !nack_q));
    assign tx_byte = mem_q[{sel_q, ptr_q[sel_q]}];

    // ----------------------------------------------------------------
    // link state machine
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            st_q <= ST_IDLE;
            xfer_q <= XFER_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_sh_q <= 8'h00;
            sel_q <= 2'h0;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end
        else if (start_det)
        begin
            // repeated start keeps the selected area and its pointer
            st_q <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end
        else if (stop_det)
        begin
            st_q <= ST_IDLE;
            xfer_q <= XFER_IDLE;
            sda_oe_q <= 1'b0;
        end
        else
        begin
            unique case (st_q)
                ST_IDLE, ST_IGNORE:
                begin
                    sda_oe_q <= 1'b0;
                end
                ST_ADDR, ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_q <= {shift_q[6:0], sda_s2_q};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    if (byte_done && st_q == ST_ADDR && addr_hit)
                    begin
                        st_q <= ST_ADDR_ACK;
                        sel_q <= hit_area;
                        rw_q <= shift_q[0];
                        xfer_q <= shift_q[0] ? XFER_SEND : XFER_REG_ADDR;
                        sda_oe_q <= 1'b1;
                    end
                    else if (byte_done && st_q == ST_ADDR)
                    begin
                        st_q <= ST_IGNORE;
                    end
                    else if (rx_done)
                    begin
                        st_q <= ST_RX_ACK;
                        sda_oe_q <= 1'b1;
                        if (xfer_q == XFER_REG_ADDR)
                        begin
                            xfer_q <= XFER_RECV;
                        end
                    end
                end
                ST_ADDR_ACK, ST_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_q <= 4'h0;
                        if (tx_load)
                        begin
                            st_q <= ST_TX;
                            sda_oe_q <= ~tx_byte[7];
                            tx_sh_q <= {tx_byte[6:0], 1'b0};
                        end
                        else
                        begin
                            st_q <= ST_RX;
                            sda_oe_q <= 1'b0;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_rise)
                    begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    if (byte_done)
                    begin
                        st_q <= ST_TX_ACK;
                        sda_oe_q <= 1'b0;
                    end
                    else if (scl_fall)
                    begin
                        sda_oe_q <= ~tx_sh_q[7];
                        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_rise)
                    begin
                        nack_q <= sda_s2_q;
                    end
                    if (tx_load)
                    begin
                        st_q <= ST_TX;
                        bit_cnt_q <= 4'h0;
                        sda_oe_q <= ~tx_byte[7];
                        tx_sh_q <= {tx_byte[6:0], 1'b0};
                    end
                    else if (scl_fall)
                    begin
                        // controller refused more data
                        st_q <= ST_IGNORE;
                    end
                end
            endcase
        end
    end

    assign SDA_OE = sda_oe_q;
    assign SDA_OUT = 1'b0;

    a_addr_reject: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (byte_done && st_q == ST_ADDR && !addr_hit && !start_det && !stop_det)
        |=> ((st_q == ST_IGNORE) && !sda_oe_q) [*2])
        else $error("unknown address was not abandoned");
    a_area_pick: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (st_q == ST_ADDR_ACK) |-> sda_oe_q && (sel_q ==
        (shift_q[7:1] == AREA_TWO_ADDRESS ? 2'h1 :
        shift_q[7:1] == AREA_THREE_ADDRESS ? 2'h2 :
        shift_q[7:1] == AREA_FOUR_ADDRESS ? 2'h3 : 2'h0)))
        else $error("wrong area selected for address");
    a_state_code: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (st_q == ST_TX || st_q == ST_TX_ACK) |-> (xfer_q == XFER_SEND))
        else $error("send state code wrong");

    // ----------------------------------------------------------------
    // area pointers and memory
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            ptr_q <= {AREA_COUNT{POINTER_RESET}};
        end
        else if (ptr_load)
        begin
            ptr_q[sel_q] <= shift_q;
        end
        else if (mem_we || tx_load)
        begin
            ptr_q[sel_q] <= ptr_q[sel_q] + 8'h01;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (mem_we)
        begin
            mem_q[{sel_q, ptr_q[sel_q]}] <= shift_q;
        end
    end

    a_ptr_step: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (mem_we || tx_load) |=> (ptr_q[$past(sel_q)] ==
        8'($past(ptr_q[sel_q]) + 8'h01)) && (sel_q == $past(sel_q)))
        else $error("pointer did not step by one");
    a_ptr_private: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (mem_we || tx_load || ptr_load) |=>
        (ptr_q[2'($past(sel_q) + 2'h1)] == $past(ptr_q[2'(sel_q + 2'h1)])))
        else $error("another area pointer moved");
    a_ptr_load: assert property (@(posedge CLK_SYS) disable iff (RESET)
        ptr_load |=> (ptr_q[$past(sel_q)] == $past(shift_q))
        ##0 (xfer_q == XFER_RECV))
        else $error("first byte did not load pointer");

    // ----------------------------------------------------------------
    // target address and last-transfer status
    // ----------------------------------------------------------------
    logic [1:0] last_q;
    logic acc, rd_last;

    assign acc = (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
    assign rd_last = acc && AVS_READ && (AVS_ADDRESS == REG_LAST);

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            target_q <= TARGET_RESET;
        end
        else if (byte_done && st_q == ST_ADDR && addr_hit)
        begin
            target_q <= shift_q;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            last_q <= XFER_IDLE;
        end
        else if (stop_det && st_q != ST_IDLE)
        begin
            // a finishing transfer wins over a clearing read
            last_q <= xfer_q;
        end
        else if (rd_last || (byte_done && st_q == ST_ADDR && addr_hit))
        begin
            last_q <= XFER_IDLE;
        end
    end

    a_target_keep: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (byte_done && st_q == ST_ADDR && addr_hit) |=> target_q == $past(shift_q))
        else $error("target address not kept");
    a_last_clear: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (rd_last && !(stop_det && st_q != ST_IDLE)) |->
        (AVS_READDATA[1:0] == $past(last_q)) ##1 (last_q == XFER_IDLE))
        else $error("last status not returned and cleared");

    // ----------------------------------------------------------------
    // interrupt status, enable, clear
    // ----------------------------------------------------------------
    logic [IRQ_WIDTH-1:0] irq_st_q, irq_en_q, irq_ev, irq_clr;

    assign irq_ev[IRQ_MATCH_BIT] = byte_done && st_q == ST_ADDR && addr_hit;
    assign irq_ev[IRQ_REJECT_BIT] = byte_done && st_q == ST_ADDR && !addr_hit;
    assign irq_ev[IRQ_DONE_BIT] = stop_det && st_q != ST_IDLE;
    assign irq_clr = (acc && AVS_WRITE && AVS_BYTEENABLE[0]
        && AVS_ADDRESS == REG_IRQ_CLEAR) ? AVS_WRITEDATA[IRQ_WIDTH-1:0]
        : IRQ_RESET;

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            irq_st_q <= IRQ_RESET;
            IRQ <= 1'b0;
        end
        else
        begin
            // a new event beats a clear in the same cycle
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
            IRQ <= |(irq_st_q & irq_en_q);
        end
    end

    // ----------------------------------------------------------------
    // register slave: one wait state per access
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h0;
        end
        else
        begin
            AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
            AVS_READDATA <= 32'h0;
            if (AVS_READ && AVS_WAITREQUEST)
            begin
                unique case (AVS_ADDRESS)
                    REG_CTRL: AVS_READDATA <= {31'h0, enable_q};
                    REG_STATE: AVS_READDATA <= {30'h0, xfer_q};
                    REG_LAST: AVS_READDATA <= {30'h0, last_q};
                    REG_TARGET: AVS_READDATA <= {24'h0, target_q};
                    REG_IRQ_STATUS: AVS_READDATA <= {29'h0, irq_st_q};
                    REG_IRQ_ENABLE: AVS_READDATA <= {29'h0, irq_en_q};
                    default: AVS_READDATA <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            enable_q <= CTRL_RESET;
            irq_en_q <= IRQ_RESET;
        end
        else if (acc && AVS_WRITE && AVS_BYTEENABLE[0])
        begin
            if (AVS_ADDRESS == REG_CTRL)
            begin
                enable_q <= AVS_WRITEDATA[0];
            end
            if (AVS_ADDRESS == REG_IRQ_ENABLE)
            begin
                irq_en_q <= AVS_WRITEDATA[IRQ_WIDTH-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // lamp display
    // ----------------------------------------------------------------
    logic [31:0] tick_cnt_q;
    logic [7:0] disp_q;
    logic show_high_q, tick;

    assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            tick_cnt_q <= 32'h0;
            show_high_q <= 1'b0;
            disp_q <= TARGET_RESET;
            LAMP_DATA_N <= {4{LAMP_OFF_LEVEL}};
            LAMP_SEL_LOW_N <= LAMP_OFF_LEVEL;
            LAMP_SEL_HIGH_N <= LAMP_OFF_LEVEL;
        end
        else
        begin
            tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
            if (tick)
            begin
                // value is sampled once per slot so a nibble never tears
                show_high_q <= ~show_high_q;
                disp_q <= target_q;
                LAMP_DATA_N <= show_high_q ? ~disp_q[7:4] : ~disp_q[3:0];
                LAMP_SEL_LOW_N <= show_high_q ? LAMP_OFF_LEVEL
                    : LAMP_ON_LEVEL;
                LAMP_SEL_HIGH_N <= show_high_q ? LAMP_ON_LEVEL
                    : LAMP_OFF_LEVEL;
            end
        end
    end

    a_lamp_swap: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (tick && !RESET) |=> (show_high_q != $past(show_high_q))
        ##1 (tick_cnt_q == 32'h1) && $stable(show_high_q))
        else $error("display slot did not switch on tick");
    a_lamp_one_sel: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $past(tick) |-> (LAMP_SEL_LOW_N != LAMP_SEL_HIGH_N)
        && (LAMP_SEL_LOW_N == $past(show_high_q)))
        else $error("lamp select levels wrong");

endmodule

// ==== mais_ctl_model.sv ====
// Purpose: two-wire bus controller model driving the target
// Assumes: line has a pull-up; sda output 1 releases the line
// Notes: clock stands high outside frames; no clock stretching seen
`timescale 1ns/1ps

module mais_ctl_model
(
    input wire logic clk, // system clock
    input wire logic sda_line, // resolved data wire
    output logic scl, // bus clock
    output logic sda // data drive, 1 releases
);
    localparam int HALF = 20;
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // data changes 5 cycles after scl fall, well clear of the edges
    task automatic bit_io(input logic b, output logic s);
        repeat (5) @(posedge clk);
        sda <= b;
        repeat (HALF - 5) @(posedge clk);
        scl <= 1'b1;
        repeat (HALF / 2) @(posedge clk);
        s = sda_line;
        repeat (HALF / 2) @(posedge clk);
        scl <= 1'b0;
    endtask
    // also serves as repeated start from scl low
    // sda moves well after scl falls, so no false start or stop is seen
    task automatic start();
        repeat (5) @(posedge clk);
        sda <= 1'b1;
        repeat (HALF) @(posedge clk);
        scl <= 1'b1;
        repeat (HALF) @(posedge clk);
        sda <= 1'b0;
        repeat (HALF) @(posedge clk);
        scl <= 1'b0;
    endtask
    task automatic stop();
        repeat (5) @(posedge clk);
        sda <= 1'b0;
        repeat (HALF) @(posedge clk);
        scl <= 1'b1;
        repeat (HALF) @(posedge clk);
        sda <= 1'b1;
        repeat (HALF) @(posedge clk);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    // nack on the last byte ends the read
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(nack, s);
    endtask
endmodule

// ==== multi_address_i2c_memory_slave_bench.sv ====
// Purpose: self-checking bench for the multi-address two-wire target
// Assumes: one wait state on the register bus; lamp tick shortened to 50
// Notes: memory contents are written before any read of them
`timescale 1ns/1ps

module multi_address_i2c_memory_slave_bench;
    import mais_pkg::*;
    localparam int TICK = 50;
    logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic avs_waitrequest, irq, scl, sda_ctl, sda_out, sda_oe, sel_l, sel_h;
    logic [3:0] lamp;
    logic sda_line;
    int n_fail = 0, check_count = 0;
    logic [6:0] areas [4] = '{AREA_ONE_ADDRESS, AREA_TWO_ADDRESS,
                              AREA_THREE_ADDRESS, AREA_FOUR_ADDRESS};
    // open drain with pull-up
    assign sda_line = (sda_oe ? sda_out : 1'b1) & sda_ctl;
    always #2.5 clk = ~clk;
    mais_top #(.TICK_CYCLES(TICK)) i_mais_top (.CLK_SYS(clk), .RESET(rst),
        .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq), .SCL_IN(scl),
        .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .LAMP_DATA_N(lamp), .LAMP_SEL_LOW_N(sel_l), .LAMP_SEL_HIGH_N(sel_h));
    mais_ctl_model i_mais_ctl_model (.clk(clk), .sda_line(sda_line),
        .scl(scl), .sda(sda_ctl));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic avs(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic reg_chk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        avs(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask
    function automatic logic [7:0] dat(input int i, input int k);
        return 8'(i * 16 + k + 5);
    endfunction
    task automatic finish_test();
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check({sda_oe, sel_l, sel_h, lamp}, 7'h3f);
        reg_chk(REG_CTRL, 32'h1);
        reg_chk(REG_TARGET, 32'h0);
        reg_chk(REG_STATE, 32'h0);
        reg_chk(5'h1c, 32'h0);
    endtask
    // write three bytes over the ff wrap, read two back, per area
    task automatic t_areas();
        logic ack;
        logic [7:0] d;
        for (int i = 0; i < 4; i++)
        begin
            i_mais_ctl_model.start();
            i_mais_ctl_model.wr_byte({areas[i], 1'b0}, ack);
            check(ack, 1'b1);
            reg_chk(REG_STATE, 32'h1);
            i_mais_ctl_model.wr_byte(8'hff, ack);
            reg_chk(REG_STATE, 32'h3);
            for (int k = 0; k < 3; k++)
                i_mais_ctl_model.wr_byte(dat(i, k), ack);
            i_mais_ctl_model.stop();
            reg_chk(REG_LAST, 32'h3);
            reg_chk(REG_LAST, 32'h0);
            reg_chk(REG_TARGET, {24'h0, areas[i], 1'b0});
            i_mais_ctl_model.start();
            i_mais_ctl_model.wr_byte({areas[i], 1'b0}, ack);
            i_mais_ctl_model.wr_byte(8'hff, ack);
            i_mais_ctl_model.start();
            i_mais_ctl_model.wr_byte({areas[i], 1'b1}, ack);
            reg_chk(REG_STATE, 32'h2);
            i_mais_ctl_model.rd_byte(1'b0, d);
            check(d, dat(i, 0));
            i_mais_ctl_model.rd_byte(1'b1, d);
            check(d, dat(i, 1));
            i_mais_ctl_model.stop();
            reg_chk(REG_STATE, 32'h0);
        end
        // area one pointer must have survived the other areas
        i_mais_ctl_model.start();
        i_mais_ctl_model.wr_byte({areas[0], 1'b1}, ack);
        i_mais_ctl_model.rd_byte(1'b1, d);
        i_mais_ctl_model.stop();
        check(d, dat(0, 2));
    endtask
    task automatic t_reject_irq();
        logic ack;
        logic [31:0] q;
        avs(1'b1, REG_IRQ_ENABLE, 32'h2, q);
        reg_chk(REG_IRQ_STATUS, 32'h5);
        reg_chk(REG_IRQ_ENABLE, 32'h2);
        check(irq, 1'b0);
        i_mais_ctl_model.start();
        i_mais_ctl_model.wr_byte(8'ha0, ack);
        check(ack, 1'b0);
        i_mais_ctl_model.wr_byte(8'h00, ack);
        check(ack, 1'b0);
        i_mais_ctl_model.stop();
        // a disabled target must refuse even a known address
        avs(1'b1, REG_CTRL, 32'h0, q);
        reg_chk(REG_CTRL, 32'h0);
        i_mais_ctl_model.start();
        i_mais_ctl_model.wr_byte({areas[1], 1'b0}, ack);
        check(ack, 1'b0);
        i_mais_ctl_model.stop();
        avs(1'b1, REG_CTRL, 32'h1, q);
        reg_chk(REG_TARGET, {24'h0, areas[0], 1'b1});
        check(irq, 1'b1);
        avs(1'b1, REG_IRQ_CLEAR, 32'h7, q);
        reg_chk(REG_IRQ_STATUS, 32'h0);
        check(irq, 1'b0);
    endtask
    task automatic t_lamps();
        int n;
        for (int j = 0; j < 3; j++)
        begin
            @(posedge clk);
            while (sel_l !== 1'b0) @(posedge clk);
            while (sel_l !== 1'b1) @(posedge clk);
        end
        while (sel_l !== 1'b0) @(posedge clk);
        check({sel_h, lamp}, {1'b1, ~4'h1});
        n = 0;
        while (sel_h !== 1'b0)
        begin
            @(posedge clk);
            n++;
        end
        check(n, TICK);
        check({sel_l, lamp}, {1'b1, ~4'h2});
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_areas();
        t_reject_irq();
        t_lamps();
        finish_test();
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        n_fail++;
        finish_test();
    end
endmodule
